// file: hw/crc_pkg.sv
// Package of constants and carrier types for the continuous record controller
package crc_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_DURATION = 8'h04;
    localparam logic [7:0] REG_HISTORY  = 8'h08;
    localparam logic [7:0] REG_CHAN_EN  = 8'h0c;
    localparam logic [7:0] REG_STATUS   = 8'h10;
    localparam logic [7:0] REG_OVR_CNT  = 8'h14;

    // Control register fields
    localparam int CTRL_START_BIT  = 0;
    localparam int CTRL_STOP_BIT   = 1;
    localparam int CTRL_POLICY_LSB = 4;

    // Status register fields
    localparam int STAT_REC_BIT   = 0;
    localparam int STAT_SUSP_BIT  = 1;
    localparam int STAT_WRAP_BIT  = 2;
    localparam int STAT_FULL_BIT  = 3;
    localparam int STAT_EMPTY_BIT = 4;
    localparam int STAT_STATE_LSB = 8;
    localparam int STAT_END_LSB   = 12;

    // Reset values
    localparam logic [31:0] DURATION_RST = 32'h0000_0000;
    localparam logic [31:0] HISTORY_RST  = 32'h0000_0000;
    localparam logic [1:0]  POLICY_RST   = 2'h0;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Marker word written into the stream after each overrun gap
    localparam logic [31:0] OVR_MARKER = 32'hdead_0f0f;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        POL_STANDARD = 2'h0,
        POL_CIRCULAR = 2'h1,
        POL_TIMED    = 2'h2,
        POL_TRIGGER  = 2'h3
    } crc_policy_t;

    // Gray codes along idle -> record -> suspend -> marker
    typedef enum logic [1:0] {
        ST_IDLE    = 2'h0,
        ST_RECORD  = 2'h1,
        ST_SUSPEND = 2'h3,
        ST_MARKER  = 2'h2
    } crc_state_t;

    // Why the last recording ended
    typedef enum logic [2:0] {
        END_NONE = 3'h0,
        END_USER = 3'h1,
        END_FULL = 3'h2,
        END_TIME = 3'h3,
        END_TRIG = 3'h4
    } crc_end_t;

    // Storage-side word with marker flag
    typedef struct packed {
        logic        marker;
        logic [31:0] data;
    } crc_word_t;

endpackage

// file: hw/crc_fifo.sv
// Continuous FIFO memory between capture and storage
`timescale 1ns/100ps
module crc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    // Write side
    input  wire logic             wr_valid_i,
    output logic                  wr_ready_o,
    input  wire logic [WIDTH-1:0] wr_data_i,
    // Read side
    output logic                  rd_valid_o,
    input  wire logic             rd_ready_i,
    output logic      [WIDTH-1:0] rd_data_o,
    // Status
    output logic                  full_o,
    output logic                  empty_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } crc_fifo_st_t;

    crc_fifo_st_t     s_q;
    crc_fifo_st_t     s_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             wr_go;
    logic             rd_go;

    // Handshake terms
    assign full_o     = (s_q.cnt == (AW+1)'(DEPTH));
    assign empty_o    = (s_q.cnt == '0);
    assign wr_ready_o = ~full_o;
    assign rd_valid_o = ~empty_o;
    assign rd_data_o  = mem[s_q.rp];
    assign wr_go      = wr_valid_i & wr_ready_o;
    assign rd_go      = rd_ready_i & rd_valid_o;

    // Pointer and count update
    always_comb begin
        s_d = s_q;
        if (wr_go) begin
            s_d.wp = (s_q.wp == AW'(DEPTH-1)) ? '0 : s_q.wp + 1'b1;
        end
        if (rd_go) begin
            s_d.rp = (s_q.rp == AW'(DEPTH-1)) ? '0 : s_q.rp + 1'b1;
        end
        s_d.cnt = s_q.cnt + (AW+1)'(wr_go) - (AW+1)'(rd_go);
    end

    // State register
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Storage array
    always_ff @(posedge clk_i) begin
        if (wr_go) begin
            mem[s_q.wp] <= wr_data_i;
        end
    end
endmodule

// file: hw/crc_axil.sv
// AXI4-Lite register slave for the continuous record controller
`timescale 1ns/100ps
module crc_axil (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // AXI4-Lite
    input  wire logic [7:0]  awaddr_i,
    input  wire logic        awvalid_i,
    output logic             awready_o,
    input  wire logic [31:0] wdata_i,
    input  wire logic [3:0]  wstrb_i,
    input  wire logic        wvalid_i,
    output logic             wready_o,
    output logic [1:0]       bresp_o,
    output logic             bvalid_o,
    input  wire logic        bready_i,
    input  wire logic [7:0]  araddr_i,
    input  wire logic        arvalid_i,
    output logic             arready_o,
    output logic [31:0]      rdata_o,
    output logic [1:0]       rresp_o,
    output logic             rvalid_o,
    input  wire logic        rready_i,
    // Register side
    output logic             we_o,
    output logic [7:0]       waddr_o,
    output logic [31:0]      wdata_o,
    output logic [3:0]       wstrb_o,
    input  wire logic        wok_i,
    output logic [7:0]       raddr_o,
    input  wire logic [31:0] rdata_i,
    input  wire logic        rok_i
);
    typedef struct packed {
        logic        aw_f;
        logic [7:0]  aw;
        logic        w_f;
        logic [31:0] w;
        logic [3:0]  ws;
        logic        bv;
        logic [1:0]  br;
        logic        rv;
        logic [31:0] rd;
        logic [1:0]  rr;
    } crc_axil_st_t;

    crc_axil_st_t s_q;
    crc_axil_st_t s_d;

    // Channel readies
    assign awready_o = ~s_q.aw_f & ~s_q.bv;
    assign wready_o  = ~s_q.w_f & ~s_q.bv;
    assign arready_o = ~s_q.rv;
    assign bvalid_o  = s_q.bv;
    assign bresp_o   = s_q.br;
    assign rvalid_o  = s_q.rv;
    assign rdata_o   = s_q.rd;
    assign rresp_o   = s_q.rr;
    assign we_o      = s_q.aw_f & s_q.w_f & ~s_q.bv;
    assign waddr_o   = s_q.aw;
    assign wdata_o   = s_q.w;
    assign wstrb_o   = s_q.ws;
    assign raddr_o   = araddr_i;

    // Channel capture and responses
    always_comb begin
        s_d = s_q;
        if (awvalid_i && awready_o) begin
            s_d.aw_f = 1'b1;
            s_d.aw   = awaddr_i;
        end
        if (wvalid_i && wready_o) begin
            s_d.w_f = 1'b1;
            s_d.w   = wdata_i;
            s_d.ws  = wstrb_i;
        end
        if (we_o) begin
            s_d.aw_f = 1'b0;
            s_d.w_f  = 1'b0;
            s_d.bv   = 1'b1;
            s_d.br   = wok_i ? crc_pkg::RESP_OKAY : crc_pkg::RESP_SLVERR;
        end
        if (s_q.bv && bready_i) begin
            s_d.bv = 1'b0;
        end
        if (arvalid_i && arready_o) begin
            s_d.rv = 1'b1;
            s_d.rd = rdata_i;
            s_d.rr = rok_i ? crc_pkg::RESP_OKAY : crc_pkg::RESP_SLVERR;
        end else if (s_q.rv && rready_i) begin
            s_d.rv = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

// file: hw/crc_top.sv
// Continuous record controller: policies, capture, overrun handling
`timescale 1ns/100ps

module crc_top #(
    parameter int NCH   = 4,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic                CLK_I,
    input  wire logic                RSTN_I,
    // AXI4-Lite register bus
    input  wire logic [7:0]          AWADDR_I,
    input  wire logic                AWVALID_I,
    output logic                     AWREADY_O,
    input  wire logic [31:0]         WDATA_I,
    input  wire logic [3:0]          WSTRB_I,
    input  wire logic                WVALID_I,
    output logic                     WREADY_O,
    output logic [1:0]               BRESP_O,
    output logic                     BVALID_O,
    input  wire logic                BREADY_I,
    input  wire logic [7:0]          ARADDR_I,
    input  wire logic                ARVALID_I,
    output logic                     ARREADY_O,
    output logic [31:0]              RDATA_O,
    output logic [1:0]               RRESP_O,
    output logic                     RVALID_O,
    input  wire logic                RREADY_I,
    // Acquisition channels and trigger
    input  wire logic                SAMPLE_STB_I,
    input  wire logic [NCH*32-1:0]   SAMPLE_DATA_I,
    input  wire logic                TRIG_I,
    // Storage sink
    output logic                     ST_VALID_O,
    input  wire logic                ST_READY_I,
    output logic [31:0]              ST_DATA_O,
    output logic                     ST_MARKER_O,
    output logic [31:0]              ST_ADDR_O,
    input  wire logic                ST_FULL_I,
    // Status
    output logic                     RECORDING_O,
    output logic                     SUSPENDED_O
);
    localparam int CW = $clog2(NCH);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        crc_pkg::crc_state_t  st;
        crc_pkg::crc_policy_t pol_cfg;
        crc_pkg::crc_policy_t pol;
        logic [31:0]          dur;
        logic [31:0]          hist;
        logic [NCH-1:0]       chen;
        logic [NCH-1:0]       chen_run;
        logic [31:0]          tcnt;
        logic [31:0]          addr;
        logic                 wrapped;
        logic [31:0]          ovr_cnt;
        crc_pkg::crc_end_t    end_why;
        logic [NCH-1:0]       pend;
        logic [NCH*32-1:0]    shot;
        logic                 st_valid;
        logic [31:0]          st_data;
        logic                 st_marker;
        logic [31:0]          st_addr;
    } crc_st_t;

    crc_st_t     s_q;
    crc_st_t     s_d;

    // Bus side signals
    logic        we;
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wok;
    logic [7:0]  raddr;
    logic [31:0] rdata;
    logic        rok;

    // FIFO signals
    logic        f_wv;
    logic        f_wr;
    logic [31:0] f_wd;
    logic        f_rv;
    logic        f_rr;
    logic [31:0] f_rd;
    logic        f_full;
    logic        f_empty;

    // Channel pick
    logic [CW-1:0] sel;
    logic          any_pend;
    logic          out_free;

    // ************************************************************
    // Register slave
    // ************************************************************
    crc_axil u_axil (
        .clk_i     (CLK_I),
        .rstn_i    (RSTN_I),
        .awaddr_i  (AWADDR_I),
        .awvalid_i (AWVALID_I),
        .awready_o (AWREADY_O),
        .wdata_i   (WDATA_I),
        .wstrb_i   (WSTRB_I),
        .wvalid_i  (WVALID_I),
        .wready_o  (WREADY_O),
        .bresp_o   (BRESP_O),
        .bvalid_o  (BVALID_O),
        .bready_i  (BREADY_I),
        .araddr_i  (ARADDR_I),
        .arvalid_i (ARVALID_I),
        .arready_o (ARREADY_O),
        .rdata_o   (RDATA_O),
        .rresp_o   (RRESP_O),
        .rvalid_o  (RVALID_O),
        .rready_i  (RREADY_I),
        .we_o      (we),
        .waddr_o   (waddr),
        .wdata_o   (wdata),
        .wstrb_o   (wstrb),
        .wok_i     (wok),
        .raddr_o   (raddr),
        .rdata_i   (rdata),
        .rok_i     (rok)
    );

    // Address decode for writes
    assign wok = (waddr == crc_pkg::REG_CTRL) || (waddr == crc_pkg::REG_DURATION)
              || (waddr == crc_pkg::REG_HISTORY) || (waddr == crc_pkg::REG_CHAN_EN);

    // Read mux with defined answer for unmapped offsets
    always_comb begin
        rdata = 32'h0000_0000;
        rok   = 1'b1;
        case (raddr)
            crc_pkg::REG_CTRL: begin
                rdata[crc_pkg::CTRL_POLICY_LSB +: 2] = s_q.pol_cfg;
            end
            crc_pkg::REG_DURATION: begin
                rdata = s_q.dur;
            end
            crc_pkg::REG_HISTORY: begin
                rdata = s_q.hist;
            end
            crc_pkg::REG_CHAN_EN: begin
                rdata[NCH-1:0] = s_q.chen;
            end
            crc_pkg::REG_STATUS: begin
                rdata[crc_pkg::STAT_REC_BIT]        = (s_q.st != crc_pkg::ST_IDLE);
                rdata[crc_pkg::STAT_SUSP_BIT]       = (s_q.st == crc_pkg::ST_SUSPEND);
                rdata[crc_pkg::STAT_WRAP_BIT]       = s_q.wrapped;
                rdata[crc_pkg::STAT_FULL_BIT]       = f_full;
                rdata[crc_pkg::STAT_EMPTY_BIT]      = f_empty;
                rdata[crc_pkg::STAT_STATE_LSB +: 2] = s_q.st;
                rdata[crc_pkg::STAT_END_LSB +: 3]   = s_q.end_why;
            end
            crc_pkg::REG_OVR_CNT: begin
                rdata = s_q.ovr_cnt;
            end
            default: begin
                rok = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // Continuous FIFO
    // ************************************************************
    crc_fifo #(
        .WIDTH (32),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_i      (CLK_I),
        .rstn_i     (RSTN_I),
        .wr_valid_i (f_wv),
        .wr_ready_o (f_wr),
        .wr_data_i  (f_wd),
        .rd_valid_o (f_rv),
        .rd_ready_i (f_rr),
        .rd_data_o  (f_rd),
        .full_o     (f_full),
        .empty_o    (f_empty)
    );

    // Lowest pending enabled channel goes first
    always_comb begin
        sel = '0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (s_q.pend[i]) begin
                sel = CW'(i);
            end
        end
    end

    assign any_pend = |s_q.pend;
    assign f_wv     = any_pend && (s_q.st == crc_pkg::ST_RECORD);
    assign f_wd     = s_q.shot[sel*32 +: 32];
    assign out_free = ~s_q.st_valid | ST_READY_I;
    assign f_rr     = out_free && (s_q.st != crc_pkg::ST_MARKER);

    // ************************************************************
    // Control
    // ************************************************************
    always_comb begin
        logic start_cmd;
        logic stop_cmd;
        logic stop_now;
        crc_pkg::crc_end_t why;
        start_cmd = 1'b0;
        stop_cmd  = 1'b0;
        stop_now  = 1'b0;
        why       = crc_pkg::END_NONE;
        s_d       = s_q;

        // Register writes
        if (we && wok) begin
            case (waddr)
                crc_pkg::REG_CTRL: begin
                    start_cmd = wstrb[0] & wdata[crc_pkg::CTRL_START_BIT];
                    stop_cmd  = wstrb[0] & wdata[crc_pkg::CTRL_STOP_BIT];
                    if (wstrb[0]) begin
                        s_d.pol_cfg = crc_pkg::crc_policy_t'(wdata[crc_pkg::CTRL_POLICY_LSB +: 2]);
                    end
                end
                crc_pkg::REG_DURATION: begin
                    s_d.dur = wdata;
                end
                crc_pkg::REG_HISTORY: begin
                    s_d.hist = wdata;
                end
                crc_pkg::REG_CHAN_EN: begin
                    s_d.chen = wdata[NCH-1:0];
                end
                default: begin
                end
            endcase
        end

        // Output stage toward storage
        if (out_free) begin
            s_d.st_valid  = 1'b0;
            s_d.st_marker = 1'b0;
        end
        if (f_rr && f_rv) begin
            s_d.st_valid  = 1'b1;
            s_d.st_data   = f_rd;
            s_d.st_marker = 1'b0;
            s_d.st_addr   = s_q.addr;
            if (s_q.pol == crc_pkg::POL_CIRCULAR && s_q.hist != '0
                    && s_q.addr == s_q.hist - 32'h1) begin
                s_d.addr    = '0;
                s_d.wrapped = 1'b1;
            end else begin
                s_d.addr = s_q.addr + 32'h1;
            end
        end

        if (f_wv && f_wr) begin
            s_d.pend[sel] = 1'b0;
        end
        if (SAMPLE_STB_I && s_q.st == crc_pkg::ST_RECORD && !any_pend) begin
            s_d.pend = s_q.chen_run;
            s_d.shot = SAMPLE_DATA_I;
        end

        if (s_q.st != crc_pkg::ST_IDLE) begin
            s_d.tcnt = s_q.tcnt + 32'h1;
            case (s_q.pol)
                crc_pkg::POL_STANDARD: begin
                    if (ST_FULL_I) begin
                        why = crc_pkg::END_FULL;
                    end else if (stop_cmd) begin
                        why = crc_pkg::END_USER;
                    end
                end
                crc_pkg::POL_CIRCULAR: begin
                    if (TRIG_I) begin
                        why = crc_pkg::END_TRIG;
                    end else if (stop_cmd) begin
                        why = crc_pkg::END_USER;
                    end
                end
                crc_pkg::POL_TIMED: begin
                    if (ST_FULL_I) begin
                        why = crc_pkg::END_FULL;
                    end else if (s_q.tcnt + 32'h1 >= s_q.dur) begin
                        why = crc_pkg::END_TIME;
                    end
                end
                crc_pkg::POL_TRIGGER: begin
                    if (ST_FULL_I) begin
                        why = crc_pkg::END_FULL;
                    end else if (TRIG_I) begin
                        why = crc_pkg::END_TRIG;
                    end
                end
                default: begin
                end
            endcase
            stop_now = (why != crc_pkg::END_NONE);
        end

        // Run state machine
        case (s_q.st)
            crc_pkg::ST_IDLE: begin
                if (start_cmd) begin
                    s_d.pol      = s_d.pol_cfg;
                    s_d.chen_run = s_d.chen;
                    s_d.tcnt     = '0;
                    s_d.addr     = '0;
                    s_d.wrapped  = 1'b0;
                    s_d.pend     = '0;
                    s_d.end_why  = crc_pkg::END_NONE;
                    s_d.st       = crc_pkg::ST_RECORD;
                end
            end
            crc_pkg::ST_RECORD: begin
                if (f_full && f_wv) begin
                    s_d.st   = crc_pkg::ST_SUSPEND;
                    s_d.pend = '0;
                end
            end
            crc_pkg::ST_SUSPEND: begin
                if (f_empty && out_free) begin
                    s_d.st = crc_pkg::ST_MARKER;
                end
            end
            crc_pkg::ST_MARKER: begin
                if (out_free) begin
                    s_d.st_valid  = 1'b1;
                    s_d.st_data   = crc_pkg::OVR_MARKER;
                    s_d.st_marker = 1'b1;
                    s_d.st_addr   = s_q.addr;
                    s_d.ovr_cnt   = s_q.ovr_cnt + 32'h1;
                    s_d.st        = crc_pkg::ST_RECORD;
                end
            end
            default: begin
                s_d.st = crc_pkg::ST_IDLE;
            end
        endcase

        if (stop_now) begin
            s_d.st      = crc_pkg::ST_IDLE;
            s_d.pend    = '0;
            s_d.end_why = why;
        end
    end

    // State register
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            s_q         <= '0;
            s_q.pol_cfg <= crc_pkg::crc_policy_t'(crc_pkg::POLICY_RST);
            s_q.dur     <= crc_pkg::DURATION_RST;
            s_q.hist    <= crc_pkg::HISTORY_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign ST_VALID_O  = s_q.st_valid;
    assign ST_DATA_O   = s_q.st_data;
    assign ST_MARKER_O = s_q.st_marker;
    assign ST_ADDR_O   = s_q.st_addr;
    assign RECORDING_O = (s_q.st != crc_pkg::ST_IDLE);
    assign SUSPENDED_O = (s_q.st == crc_pkg::ST_SUSPEND);
endmodule

// file: tb/crc_top_monitor.sv
// Port checker for the continuous record controller
`timescale 1ns/100ps
module crc_top_monitor (
    // Clock, reset and bus answers
    input wire logic        CLK_I, RSTN_I, BVALID_O, ARVALID_I, ARREADY_O, RVALID_O, RREADY_I,
    input wire logic [31:0] RDATA_O,
    // Storage side and state
    input wire logic        ST_VALID_O, ST_READY_I, ST_MARKER_O, RECORDING_O, SUSPENDED_O,
    input wire logic [31:0] ST_DATA_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    // Marker word carries the fixed value
    property p_mk; ST_VALID_O && ST_MARKER_O |-> ST_DATA_O == crc_pkg::OVR_MARKER; endproperty
    a_mk: assert property (p_mk) else $error("marker word value wrong");
    // Resume is followed by a marker word
    property p_rsm; $fell(SUSPENDED_O) |-> ##[0:8] (ST_VALID_O && ST_MARKER_O); endproperty
    a_rsm: assert property (p_rsm) else $error("no marker after resume");
    // Stalled word held unchanged
    property p_sth; ST_VALID_O && !ST_READY_I |=> ST_VALID_O && $stable(ST_DATA_O); endproperty
    a_sth: assert property (p_sth) else $error("stalled word changed");
    // Suspension only within a recording
    property p_sus; SUSPENDED_O |-> RECORDING_O; endproperty
    a_sus: assert property (p_sus) else $error("suspended while idle");
    // Recording starts only by a register write
    property p_rec; $rose(RECORDING_O) |-> BVALID_O || $past(BVALID_O); endproperty
    a_rec: assert property (p_rec) else $error("recording began without command");
    // Read answer one cycle after address
    property p_ar; ARVALID_I && ARREADY_O |=> RVALID_O; endproperty
    a_ar: assert property (p_ar) else $error("read answer late");
    // Read answer stands with stable data
    property p_rh; RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O); endproperty
    a_rh: assert property (p_rh) else $error("read answer dropped");
    // No new read address while answer pending
    property p_arb; RVALID_O |-> !ARREADY_O; endproperty
    a_arb: assert property (p_arb) else $error("read address taken while busy");
endmodule
bind crc_top crc_top_monitor u_mon (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .BVALID_O(BVALID_O),
    .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I),
    .RDATA_O(RDATA_O), .ST_VALID_O(ST_VALID_O), .ST_READY_I(ST_READY_I),
    .ST_MARKER_O(ST_MARKER_O), .RECORDING_O(RECORDING_O), .SUSPENDED_O(SUSPENDED_O),
    .ST_DATA_O(ST_DATA_O));

// file: tb/crc_sink.sv
// Storage sink model with stall and full controls
`timescale 1ns/100ps
module crc_sink (
    // Clock, word in, controls
    input wire logic        clk_i, valid_i, marker_i, stall_i, fill_i,
    input wire logic [31:0] data_i,
    // Handshake and full flag
    output logic            ready_o, full_o
);
    logic [32:0] q[$];
    // Ready and full follow the bench controls
    assign ready_o = !stall_i;
    assign full_o  = fill_i;
    // Keep every accepted word with its marker flag
    always @(posedge clk_i) if (valid_i && ready_o) q.push_back({marker_i, data_i});
endmodule

// file: tb/crc_top_test.sv
// Register-driven bench for the continuous record controller
`timescale 1ns/100ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin err_count++; \
    $display("MISMATCH %s exp %h got %h", n, e, s); end end
module crc_top_test;
    logic clk = 0, rstn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, stb = 0, trg = 0;
    logic stl = 0, fil = 0, awr, wr, bv, arr, rv, stv, stm, stf, sr, rec, sus;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rdat, rd_, std_, sta;
    logic [127:0] sd = 0;
    logic [1:0] rr, rrs, br;
    int err_count = 0, n_tests = 0, m;
    always #12.5 clk = ~clk;
    crc_top #(.NCH(4), .DEPTH(16)) dut (.CLK_I(clk), .RSTN_I(rstn), .AWADDR_I(awa),
        .AWVALID_I(awv), .AWREADY_O(awr), .WDATA_I(wd), .WSTRB_I(4'hf), .WVALID_I(wv),
        .WREADY_O(wr), .BRESP_O(br), .BVALID_O(bv), .BREADY_I(bre), .ARADDR_I(ara),
        .ARVALID_I(arv), .ARREADY_O(arr), .RDATA_O(rd_), .RRESP_O(rr), .RVALID_O(rv),
        .RREADY_I(rre), .SAMPLE_STB_I(stb), .SAMPLE_DATA_I(sd), .TRIG_I(trg),
        .ST_VALID_O(stv), .ST_READY_I(sr), .ST_DATA_O(std_), .ST_MARKER_O(stm), .ST_ADDR_O(sta),
        .ST_FULL_I(stf), .RECORDING_O(rec), .SUSPENDED_O(sus));
    crc_sink snk (.clk_i(clk), .valid_i(stv), .marker_i(stm), .stall_i(stl), .fill_i(fil),
        .data_i(std_), .ready_o(sr), .full_o(stf));
    // Response wait, ready already raised with the request
    task automatic ack(input bit r);
        do @(negedge clk); while (!(r ? rv : bv));
        rdat = rd_; rrs = r ? rr : br;
        @(posedge clk); rre <= 0; bre <= 0;
    endtask
    // Write with address and data offered together
    task automatic wrt(input logic [7:0] a, input logic [31:0] d);
        logic da, dw, ta, tw;
        @(posedge clk); awa <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1; da = 0; dw = 0;
        while (!(da && dw)) begin
            @(negedge clk); ta = awv & awr; tw = wv & wr;
            @(posedge clk); if (ta) awv <= 0; if (tw) wv <= 0; da |= ta; dw |= tw;
        end
        ack(0);
    endtask
    // Read one register
    task automatic rd(input logic [7:0] a);
        @(posedge clk); ara <= a; arv <= 1; rre <= 1;
        do @(negedge clk); while (!arr);
        @(posedge clk); arv <= 0; ack(1);
    endtask
    // One sample set, channel i word is {i, k}
    task automatic smp(input logic [23:0] k);
        @(posedge clk); stb <= 1; sd <= {8'h3, k, 8'h2, k, 8'h1, k, 8'h0, k};
        @(posedge clk); stb <= 0;
    endtask
    // End reason and recording flag from status
    task automatic stat(input logic [3:0] e);
        repeat (3) @(posedge clk);
        rd(crc_pkg::REG_STATUS); `CHK("end,rec", e, {rdat[14:12], rdat[0]})
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin #100000; err_count++; tally_and_finish; end
    // Main sequence
    initial begin
        repeat (16) @(posedge clk); rstn <= 1; @(posedge clk);
        rd(crc_pkg::REG_CTRL); `CHK("policy rst", 2'h0, rdat[5:4])
        rd(8'h3c); `CHK("unmapped", 34'h2_0000_0000, {rrs, rdat})
        wrt(8'h3c, 32'h1); `CHK("wr err", 2'h2, rrs)
        wrt(crc_pkg::REG_CHAN_EN, 32'h5); wrt(crc_pkg::REG_CTRL, 32'h1); smp(24'h1);
        repeat (10) @(posedge clk); `CHK("words", 2, snk.q.size())
        `CHK("ch0", 33'h0_0000_0001, snk.q[0]) `CHK("ch2", 33'h0_0200_0001, snk.q[1])
        fil <= 1; stat(4'h4); fil <= 0;
        for (int p = 1; p < 4; p += 2) begin
            wrt(crc_pkg::REG_CTRL, 32'(p * 16 + 1)); rd(crc_pkg::REG_CTRL);
            `CHK("policy", 2'(p), rdat[5:4])
            fil <= (p == 1); repeat (5) @(posedge clk); `CHK("rec", 1'b1, rec)
            fil <= 0; @(posedge clk); trg <= 1; @(posedge clk); trg <= 0; stat(4'h8);
        end
        wrt(crc_pkg::REG_DURATION, 32'd40); wrt(crc_pkg::REG_CTRL, 32'h21);
        repeat (10) @(posedge clk); `CHK("timed rec", 1'b1, rec)
        repeat (40) @(posedge clk); stat(4'h6);
        wrt(crc_pkg::REG_CTRL, 32'h1); wrt(crc_pkg::REG_CTRL, 32'h2); stat(4'h2);
        snk.q.delete(); stl <= 1; wrt(crc_pkg::REG_CHAN_EN, 32'hf); wrt(crc_pkg::REG_CTRL, 32'h1);
        for (int k = 0; k < 6; k++) begin smp(24'(k)); repeat (4) @(posedge clk); end
        `CHK("suspended", 1'b1, sus)
        stl <= 0; repeat (80) @(posedge clk); `CHK("resumed", 1'b0, sus)
        `CHK("first", 33'h0_0000_0000, snk.q[0])
        m = 0; foreach (snk.q[i]) m += snk.q[i][32];
        `CHK("markers", 1, m)
        `CHK("drained", 18, snk.q.size())
        `CHK("marker", {1'b1, crc_pkg::OVR_MARKER}, snk.q[17])
        rd(crc_pkg::REG_OVR_CNT); `CHK("overruns", 32'h1, rdat)
        wrt(crc_pkg::REG_CTRL, 32'h2); wrt(crc_pkg::REG_HISTORY, 32'h2);
        wrt(crc_pkg::REG_CTRL, 32'h11); smp(24'h5); repeat (8) @(posedge clk);
        `CHK("circ words", 22, snk.q.size()) `CHK("addr", 32'h1, sta)
        wrt(crc_pkg::REG_CTRL, 32'h12); stat(4'h2); `CHK("wrap", 1'b1, rdat[2])
        tally_and_finish;
    end
endmodule
